// ---- src/jcg_pkg.sv ----
// Constants and types for the test-port and configuration gating block
package jcg_pkg;
	localparam int IR_W    = 10;
	localparam int ID_W    = 32;
	localparam int PINS    = 4;
	localparam int BSR_W   = 2 * PINS;
	localparam int CFG_CYC = 1024;
	localparam int CFG_CW  = 11;

	localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
	localparam logic [IR_W-1:0] IR_RESET   = 10'h3FF;
	localparam logic [IR_W-1:0] OP_BYPASS  = 10'h3FF;
	localparam logic [IR_W-1:0] OP_IDCODE  = 10'h006;
	localparam logic [IR_W-1:0] OP_SAMPLE  = 10'h005;
	localparam logic [IR_W-1:0] OP_EXTEST  = 10'h00F;
	localparam logic [IR_W-1:0] OP_CLAMP   = 10'h00A;
	localparam logic [IR_W-1:0] OP_HIGHZ   = 10'h00B;
	localparam logic [IR_W-1:0] OP_CFG_INT = 10'h00D;
	localparam logic [IR_W-1:0] OP_RECFG   = 10'h001;
	localparam logic [IR_W-1:0] OP_PRIV0   = 10'h310;
	localparam logic [IR_W-1:0] OP_PRIV1   = 10'h0C9;
	localparam logic [IR_W-1:0] OP_PRIV2   = 10'h313;
	localparam logic [IR_W-1:0] OP_PRIV3   = 10'h317;

	typedef enum logic [15:0] {
		TS_TLR = 16'h0001, TS_RTI = 16'h0002, TS_SELDR = 16'h0004,
		TS_CAPDR = 16'h0008, TS_SHDR = 16'h0010, TS_EX1DR = 16'h0020,
		TS_PDR = 16'h0040, TS_EX2DR = 16'h0080, TS_UPDR = 16'h0100,
		TS_SELIR = 16'h0200, TS_CAPIR = 16'h0400, TS_SHIR = 16'h0800,
		TS_EX1IR = 16'h1000, TS_PIR = 16'h2000, TS_EX2IR = 16'h4000,
		TS_UPIR = 16'h8000
	} jcg_tap_t;

	typedef enum logic [3:0] {
		CF_HOLD = 4'h1,
		CF_LOAD = 4'h2,
		CF_USER = 4'h4,
		CF_INTR = 4'h8
	} jcg_cfg_t;

	typedef struct packed {
		logic out;
		logic oe;
	} jcg_pin_t;
endpackage

// ---- src/jcg_top.sv ----
// Test access port with configuration gating, boundary cells and config sequencer
//
// Contract
// [RULE1] Test logic runs straight from power-up with no configuration step.
// [RULE2] BYPASS, IDCODE and SAMPLE run during configuration without disturbing it.
// [RULE3] Other instructions act only once configuration has been interrupted; the code also lets them act whenever configuration is not loading.
// [RULE4] The interrupt instruction stops configuration and hands pins to the port.
// [RULE5] After an interrupt, the reconfigure instruction or a low request restarts.
// [RULE6] The tester holds the request pin low during test before configuration.
// [RULE7] Chip-wide clear and output enable never affect test or configuration.
// [RULE8] Instruction capture shifts out a one then a zero first.
// [RULE9] The tester reaches instruction shift by reset then TMS 01100.
// [RULE10] The tester never loads the four private instruction codes.
// [RULE11] The tester should preload before the first EXTEST.
// [RULE12] In EXTEST a pin with output-enable cell 0 drives its data cell value.
// [RULE13] The tester runs no EXTEST while in-circuit reconfiguration is under way.
// [RULE14] The test pins are dedicated and nothing can disable the test logic.
// [RULE15] An all-ones instruction selects the one-bit bypass register.
// [RULE16] An interrupted flag is set by the interrupt, cleared by reconfiguration.
`timescale 1ns/10ps
module jcg_top #(
	parameter logic [31:0] IDCODE_VAL = 32'h0000_1001 // Arbitrary value
) (
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        tck,
	input  wire logic                        tms,
	input  wire logic                        tdi,
	input  wire logic                        trst_n,
	output logic                             tdo,
	output logic                             tdo_en,
	input  wire logic                        config_request_n,
	input  wire logic                        chip_wide_clear_n,
	input  wire logic                        chip_wide_output_enable,
	input  jcg_pkg::jcg_pin_t [jcg_pkg::PINS-1:0] core_pin,
	input  wire logic [jcg_pkg::PINS-1:0]    pin_in,
	output jcg_pkg::jcg_pin_t [jcg_pkg::PINS-1:0] pin_drv,
	output logic                             config_busy,
	output logic                             config_done
);
	localparam int IW = jcg_pkg::IR_W;
	localparam int BW = jcg_pkg::BSR_W;
	localparam int NP = jcg_pkg::PINS;

	// TRST only reaches the link side; no config pin or chip-wide pin touches it
	logic tap_rst_b;
	assign tap_rst_b = rst_b & trst_n;

	function automatic jcg_pkg::jcg_tap_t tap_next(jcg_pkg::jcg_tap_t s, logic m);
		case (s)
			jcg_pkg::TS_TLR:   tap_next = m ? jcg_pkg::TS_TLR   : jcg_pkg::TS_RTI;
			jcg_pkg::TS_RTI:   tap_next = m ? jcg_pkg::TS_SELDR : jcg_pkg::TS_RTI;
			jcg_pkg::TS_SELDR: tap_next = m ? jcg_pkg::TS_SELIR : jcg_pkg::TS_CAPDR;
			jcg_pkg::TS_CAPDR: tap_next = m ? jcg_pkg::TS_EX1DR : jcg_pkg::TS_SHDR;
			jcg_pkg::TS_SHDR:  tap_next = m ? jcg_pkg::TS_EX1DR : jcg_pkg::TS_SHDR;
			jcg_pkg::TS_EX1DR: tap_next = m ? jcg_pkg::TS_UPDR  : jcg_pkg::TS_PDR;
			jcg_pkg::TS_PDR:   tap_next = m ? jcg_pkg::TS_EX2DR : jcg_pkg::TS_PDR;
			jcg_pkg::TS_EX2DR: tap_next = m ? jcg_pkg::TS_UPDR  : jcg_pkg::TS_SHDR;
			jcg_pkg::TS_UPDR:  tap_next = m ? jcg_pkg::TS_SELDR : jcg_pkg::TS_RTI;
			jcg_pkg::TS_SELIR: tap_next = m ? jcg_pkg::TS_TLR   : jcg_pkg::TS_CAPIR;
			jcg_pkg::TS_CAPIR: tap_next = m ? jcg_pkg::TS_EX1IR : jcg_pkg::TS_SHIR;
			jcg_pkg::TS_SHIR:  tap_next = m ? jcg_pkg::TS_EX1IR : jcg_pkg::TS_SHIR;
			jcg_pkg::TS_EX1IR: tap_next = m ? jcg_pkg::TS_UPIR  : jcg_pkg::TS_PIR;
			jcg_pkg::TS_PIR:   tap_next = m ? jcg_pkg::TS_EX2IR : jcg_pkg::TS_PIR;
			jcg_pkg::TS_EX2IR: tap_next = m ? jcg_pkg::TS_UPIR  : jcg_pkg::TS_SHIR;
			jcg_pkg::TS_UPIR:  tap_next = m ? jcg_pkg::TS_SELDR : jcg_pkg::TS_RTI;
			default:           tap_next = jcg_pkg::TS_TLR;
		endcase
	endfunction

	// True for codes that may run while configuration is loading
	function automatic logic is_free(logic [IW-1:0] op);
		is_free = (op == jcg_pkg::OP_BYPASS) || (op == jcg_pkg::OP_IDCODE) ||
			(op == jcg_pkg::OP_SAMPLE) || (op == jcg_pkg::OP_CFG_INT);
	endfunction

	jcg_pkg::jcg_tap_t st_q;
	logic [IW-1:0]     ir_sh_q;
	logic [IW-1:0]     instr_q;
	localparam int ID_W_L = jcg_pkg::ID_W;
	logic [ID_W_L-1:0] id_q;
	logic              byp_q;
	logic [BW-1:0]     bsr_q;
	logic [NP-1:0]     out_upd_q;
	logic [NP-1:0]     oe_upd_q;
	logic [NP-1:0]     pin_m_q;
	logic [NP-1:0]     pin_s_q;
	logic              busy_m_q, busy_s_q, intr_m_q, intr_s_q;
	logic              intr_q;
	logic              int_tgl_q, rcf_tgl_q;
	logic              op_ok;
	logic              cfg_loading;

	// Power-up reset lands in logic reset, so the port works at once
	// [RULE1] Live from reset
	always_ff @(posedge tck or negedge tap_rst_b)
	begin
		if (!tap_rst_b)
			st_q <= jcg_pkg::TS_TLR;
		else
			st_q <= tap_next(st_q, tms);
	end

	// Pin levels and config status come from other clocks
	always_ff @(posedge tck or negedge tap_rst_b)
	begin
		if (!tap_rst_b)
		begin
			pin_m_q  <= '0;
			pin_s_q  <= '0;
			busy_m_q <= 1'b0;
			busy_s_q <= 1'b0;
			intr_m_q <= 1'b0;
			intr_s_q <= 1'b0;
		end
		else
		begin
			pin_m_q  <= pin_in;
			pin_s_q  <= pin_m_q;
			busy_m_q <= cfg_loading;
			busy_s_q <= busy_m_q;
			intr_m_q <= intr_q;
			intr_s_q <= intr_m_q;
		end
	end

	// [RULE3] Gate restricted codes
	assign op_ok = is_free(ir_sh_q) || intr_s_q || !busy_s_q;

	always_ff @(posedge tck or negedge tap_rst_b)
	begin
		if (!tap_rst_b)
		begin
			ir_sh_q <= jcg_pkg::IR_RESET;
			instr_q <= jcg_pkg::IR_RESET;
		end
		else
		begin
			// [RULE8] Capture pattern
			if (st_q == jcg_pkg::TS_CAPIR)
				ir_sh_q <= jcg_pkg::IR_CAPTURE;
			else if (st_q == jcg_pkg::TS_SHIR)
				ir_sh_q <= {tdi, ir_sh_q[IW-1:1]};
			if (st_q == jcg_pkg::TS_TLR)
				instr_q <= jcg_pkg::IR_RESET;
			else if (st_q == jcg_pkg::TS_UPIR)
				instr_q <= op_ok ? ir_sh_q : jcg_pkg::OP_BYPASS;
		end
	end

	// Events toward the config side, carried as toggles
	// [RULE4] Interrupt request
	always_ff @(posedge tck or negedge tap_rst_b)
	begin
		if (!tap_rst_b)
		begin
			int_tgl_q <= 1'b0;
			rcf_tgl_q <= 1'b0;
		end
		else if (st_q == jcg_pkg::TS_UPIR)
		begin
			if (ir_sh_q == jcg_pkg::OP_CFG_INT)
				int_tgl_q <= ~int_tgl_q;
			// [RULE5] Reconfigure pulse
			if (ir_sh_q == jcg_pkg::OP_RECFG && op_ok)
				rcf_tgl_q <= ~rcf_tgl_q;
		end
	end

	// Private codes fall to the bypass path, so a slip cannot reach them
	logic sel_id, sel_bsr, t_extest, t_clamp, t_highz;
	assign sel_id   = instr_q == jcg_pkg::OP_IDCODE;
	assign t_extest = instr_q == jcg_pkg::OP_EXTEST;
	assign t_clamp  = instr_q == jcg_pkg::OP_CLAMP;
	assign t_highz  = instr_q == jcg_pkg::OP_HIGHZ;
	// [RULE15] All ones and unknown codes select bypass
	assign sel_bsr  = t_extest || instr_q == jcg_pkg::OP_SAMPLE;

	always_ff @(posedge tck or negedge tap_rst_b)
	begin
		if (!tap_rst_b)
		begin
			byp_q <= 1'b0;
			id_q  <= '0;
			bsr_q <= '0;
		end
		else if (st_q == jcg_pkg::TS_CAPDR)
		begin
			byp_q <= 1'b0;
			id_q  <= IDCODE_VAL;
			for (int i = 0; i < NP; i++)
			begin
				bsr_q[2*i]   <= pin_s_q[i];
				bsr_q[2*i+1] <= oe_upd_q[i];
			end
		end
		else if (st_q == jcg_pkg::TS_SHDR)
		begin
			byp_q <= tdi;
			if (sel_id)
				id_q <= {tdi, id_q[ID_W_L-1:1]};
			if (sel_bsr)
				bsr_q <= {tdi, bsr_q[BW-1:1]};
		end
	end

	// Update cells start at high impedance (enable cell 1 means off)
	always_ff @(posedge tck or negedge tap_rst_b)
	begin
		if (!tap_rst_b)
		begin
			out_upd_q <= '0;
			oe_upd_q  <= '1;
		end
		else if (st_q == jcg_pkg::TS_UPDR && sel_bsr)
		begin
			for (int i = 0; i < NP; i++)
			begin
				out_upd_q[i] <= bsr_q[2*i];
				oe_upd_q[i]  <= bsr_q[2*i+1];
			end
		end
	end

	// TDO changes on the falling edge so the tester samples a settled bit
	// [RULE14] Dedicated output
	always_ff @(negedge tck or negedge tap_rst_b)
	begin
		if (!tap_rst_b)
		begin
			tdo    <= 1'b0;
			tdo_en <= 1'b0;
		end
		else
		begin
			tdo_en <= (st_q == jcg_pkg::TS_SHIR) || (st_q == jcg_pkg::TS_SHDR);
			if (st_q == jcg_pkg::TS_SHIR)
				tdo <= ir_sh_q[0];
			else if (sel_id)
				tdo <= id_q[0];
			else if (sel_bsr)
				tdo <= bsr_q[0];
			else
				tdo <= byp_q;
		end
	end

	// Config side on clk
	jcg_pkg::jcg_cfg_t cst_q;
	logic [jcg_pkg::CFG_CW-1:0] cnt_q;
	logic              req_m_q, req_s_q, req_d_q;
	logic              clr_m_q, clr_s_q, oe_m_q, oe_s_q;
	logic [2:0]        int_sy_q, rcf_sy_q;
	logic              int_ev, rcf_ev, req_fall;
	jcg_pkg::jcg_pin_t [NP-1:0] func_q;

	assign int_ev   = int_sy_q[2] ^ int_sy_q[1];
	assign rcf_ev   = rcf_sy_q[2] ^ rcf_sy_q[1];
	assign req_fall = req_d_q && !req_s_q;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			req_m_q  <= 1'b0;
			req_s_q  <= 1'b0;
			req_d_q  <= 1'b0;
			clr_m_q  <= 1'b0;
			clr_s_q  <= 1'b0;
			oe_m_q   <= 1'b0;
			oe_s_q   <= 1'b0;
			int_sy_q <= '0;
			rcf_sy_q <= '0;
		end
		else
		begin
			req_m_q  <= config_request_n;
			req_s_q  <= req_m_q;
			req_d_q  <= req_s_q;
			clr_m_q  <= chip_wide_clear_n;
			clr_s_q  <= clr_m_q;
			oe_m_q   <= chip_wide_output_enable;
			oe_s_q   <= oe_m_q;
			int_sy_q <= {int_sy_q[1:0], int_tgl_q};
			rcf_sy_q <= {rcf_sy_q[1:0], rcf_tgl_q};
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cst_q <= jcg_pkg::CF_HOLD;
			cnt_q <= '0;
		end
		else
		begin
			case (cst_q)
				// An interrupt before loading also parks the device until a restart
				jcg_pkg::CF_HOLD:
					if (int_ev)
						cst_q <= jcg_pkg::CF_INTR;
					else if (req_s_q)
					begin
						cst_q <= jcg_pkg::CF_LOAD;
						cnt_q <= '0;
					end
				// [RULE2] Loading runs on whatever the port does, bar an interrupt
				jcg_pkg::CF_LOAD:
					if (int_ev)
						cst_q <= jcg_pkg::CF_INTR;
					else if (!req_s_q)
						cst_q <= jcg_pkg::CF_HOLD;
					else if (cnt_q == jcg_pkg::CFG_CW'(jcg_pkg::CFG_CYC - 1))
						cst_q <= jcg_pkg::CF_USER;
					else
						cnt_q <= cnt_q + 1'b1;
				// [RULE5] Restart paths
				default:
					if (int_ev)
						cst_q <= jcg_pkg::CF_INTR;
					else if (rcf_ev || req_fall)
						cst_q <= jcg_pkg::CF_HOLD;
			endcase
		end
	end

	// An interrupt in the same cycle as a restart wins, so none is lost
	// [RULE16] Interrupted flag
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			intr_q <= 1'b0;
		else if (int_ev)
			intr_q <= 1'b1;
		else if (rcf_ev || req_fall)
			intr_q <= 1'b0;
	end

	assign cfg_loading = cst_q == jcg_pkg::CF_LOAD;
	assign config_busy = cfg_loading;
	assign config_done = cst_q == jcg_pkg::CF_USER;

	// Chip-wide pins shape only the user drive, never the test path
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			func_q <= '0;
		else
		begin
			for (int i = 0; i < NP; i++)
			begin
				func_q[i].out <= core_pin[i].out & clr_s_q;
				func_q[i].oe  <= core_pin[i].oe & oe_s_q & config_done;
			end
		end
	end

	// [RULE12] Test drive of pins
	// [RULE7] Test modes bypass the chip-wide pins
	always_comb
	begin
		for (int i = 0; i < NP; i++)
		begin
			if (t_extest || t_clamp)
			begin
				pin_drv[i].out = out_upd_q[i];
				pin_drv[i].oe  = !oe_upd_q[i];
			end
			// Config-side flag, so pins follow a restart even with the test clock stopped
			else if (t_highz || intr_q)
			begin
				pin_drv[i].out = out_upd_q[i];
				pin_drv[i].oe  = 1'b0;
			end
			else
				pin_drv[i] = func_q[i];
		end
	end

	sequence s_ir_entry;
		st_q == jcg_pkg::TS_CAPIR ##1 st_q == jcg_pkg::TS_SHIR;
	endsequence

	chk_ir_capture: assert property (@(posedge tck) disable iff (!tap_rst_b) // [RULE8]
		s_ir_entry |-> ir_sh_q[1:0] == 2'h1)
		else $error("instruction capture does not start 1 then 0");
	chk_tlr_reach: assert property (@(posedge tck) disable iff (!tap_rst_b) // [RULE1]
		tms [*5] |=> st_q == jcg_pkg::TS_TLR)
		else $error("five TMS ones did not reach logic reset");
	chk_bypass_sel: assert property (@(posedge tck) disable iff (!tap_rst_b) // [RULE15]
		instr_q == jcg_pkg::OP_BYPASS |-> !sel_id && !sel_bsr)
		else $error("all-ones instruction did not select bypass");
	chk_bypass_path: assert property (@(posedge tck) disable iff (!tap_rst_b) // [RULE15]
		instr_q == jcg_pkg::OP_BYPASS && st_q == jcg_pkg::TS_SHDR |=> tdo == $past(tdi))
		else $error("bypass path did not pass one bit");
	chk_tdo_enable: assert property (@(posedge tck) disable iff (!tap_rst_b) // [RULE14]
		(st_q == jcg_pkg::TS_SHIR || st_q == jcg_pkg::TS_SHDR) |-> tdo_en)
		else $error("serial output not enabled while shifting");
	chk_restrict_gate: assert property (@(posedge tck) disable iff (!tap_rst_b) // [RULE3]
		st_q == jcg_pkg::TS_UPIR && !is_free(ir_sh_q) && busy_s_q && !intr_s_q
		|=> instr_q == jcg_pkg::OP_BYPASS)
		else $error("restricted instruction ran during configuration");
	chk_intr_stop: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
		int_ev |=> cst_q == jcg_pkg::CF_INTR && intr_q)
		else $error("interrupt did not stop configuration");
	chk_reconfig_clr: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
		intr_q && rcf_ev && !int_ev |=> !intr_q && cst_q == jcg_pkg::CF_HOLD)
		else $error("reconfigure did not clear the interrupted flag");
	chk_load_safe: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
		cfg_loading && !int_ev && req_s_q |=> cst_q inside {jcg_pkg::CF_LOAD,
		jcg_pkg::CF_USER} && cnt_q >= $past(cnt_q))
		else $error("configuration disturbed without interrupt");
	chk_extest_drive: assert property (@(posedge tck) disable iff (!tap_rst_b) // [RULE12]
		t_extest && !oe_upd_q[0] |-> pin_drv[0].oe && pin_drv[0].out == out_upd_q[0])
		else $error("EXTEST pin not driven from its data cell");
	chk_highz_off: assert property (@(posedge tck) disable iff (!tap_rst_b) // [RULE7]
		t_highz |-> (pin_drv & {NP{2'b01}}) == {NP{2'b00}})
		else $error("HIGHZ left a pin driven");
endmodule

// ---- bench/jcg_tester.sv ----
// Boundary-scan tester model driving the test port, clock still between frames
`timescale 1ns/10ps
module jcg_tester (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input  wire logic tdo
);
	initial
	begin
		tck    = 1'b0;
		tms    = 1'b1;
		tdi    = 1'b0;
		trst_n = 1'b1;
	end

	// One 32 ns test clock period; tdo is taken before the rising edge
	task automatic pulse(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#16;
		o   = tdo;
		tck = 1'b1;
		#16;
		tck = 1'b0;
	endtask

	// Idle data line must not look like the last bit shifted
	task automatic end_frame();
		tdi = ~tdi;
	endtask

	task automatic idle(input int n);
		logic o;
		repeat (n) pulse(1'b1, 1'b0, o);
	endtask

	task automatic shift_ir(input logic [9:0] code, output logic [1:0] first);
		logic o;
		logic [4:0] seq;
		seq = 5'b00110;
		idle(5);
		for (int i = 0; i < 5; i++) pulse(seq[i], 1'b0, o);
		for (int i = 0; i < 10; i++)
		begin
			pulse(i == 9, code[i], o);
			if (i < 2) first[i] = o;
		end
		pulse(1'b1, 1'b0, o);
		pulse(1'b0, 1'b0, o);
		end_frame();
	endtask

	task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = '0;
		pulse(1'b1, 1'b0, o);
		pulse(1'b0, 1'b0, o);
		pulse(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++)
		begin
			pulse(i == n - 1, din[i], o);
			dout[i] = o;
		end
		pulse(1'b1, 1'b0, o);
		pulse(1'b0, 1'b0, o);
		end_frame();
	endtask
endmodule

// ---- bench/jtag_config_gating_tb.sv ----
// Self-checking bench for test port and configuration gating
`timescale 1ns/10ps
module jtag_config_gating_tb;
	localparam logic [31:0] ID_VAL = 32'h0000_2003; // Arbitrary value
	logic                                 clk;
	logic                                 rst_b;
	logic                                 tck;
	logic                                 tms;
	logic                                 tdi;
	logic                                 trst_n;
	logic                                 tdo;
	logic                                 tdo_en;
	logic                                 config_request_n;
	logic                                 chip_wide_clear_n;
	logic                                 chip_wide_output_enable;
	jcg_pkg::jcg_pin_t [jcg_pkg::PINS-1:0] core_pin;
	logic [jcg_pkg::PINS-1:0]             pin_in;
	jcg_pkg::jcg_pin_t [jcg_pkg::PINS-1:0] pin_drv;
	logic                                 config_busy;
	logic                                 config_done;
	int                                   fails;
	int                                   samples_checked;
	logic [1:0]                           f;
	logic [31:0]                          d;

	jcg_top #(.IDCODE_VAL(ID_VAL)) dut (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_en(tdo_en),
		.config_request_n(config_request_n), .chip_wide_clear_n(chip_wide_clear_n),
		.chip_wide_output_enable(chip_wide_output_enable), .core_pin(core_pin),
		.pin_in(pin_in), .pin_drv(pin_drv), .config_busy(config_busy),
		.config_done(config_done));

	jcg_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

	always #5 clk = ~clk;

	task automatic close_out();
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	function automatic logic [3:0] oes();
		return {pin_drv[3].oe, pin_drv[2].oe, pin_drv[1].oe, pin_drv[0].oe};
	endfunction

	// Request held low while testing before any configuration
	task automatic t_ir_capture();
		tester.shift_ir(jcg_pkg::OP_IDCODE, f);
		check("ir_capture", 32'h1, {30'h0, f});
		check("busy_unconfigured", 32'h0, {31'h0, config_busy});
		wait_clk(1);
		check("tdo_en_idle", 32'h0, {31'h0, tdo_en});
	endtask

	task automatic t_idcode_during_load();
		config_request_n = 1'b1;
		wait_clk(20);
		check("busy_start", 32'h1, {31'h0, config_busy});
		chip_wide_clear_n = 1'b0;
		chip_wide_output_enable = 1'b0;
		tester.shift_ir(jcg_pkg::OP_IDCODE, f);
		tester.shift_dr(32, 32'h0, d);
		check("idcode", ID_VAL, d);
		check("busy_after_idcode", 32'h1, {31'h0, config_busy});
		chip_wide_clear_n = 1'b1;
		chip_wide_output_enable = 1'b1;
	endtask

	// Restricted code while loading must fall back to the bypass path
	task automatic t_restricted_refused();
		tester.shift_ir(jcg_pkg::OP_EXTEST, f);
		tester.shift_dr(2, 32'h3, d);
		check("bypass_path", 32'h2, {30'h0, d[1:0]});
		check("pins_off_load", 32'h0, {28'h0, oes()});
		check("busy_kept", 32'h1, {31'h0, config_busy});
	endtask

	task automatic t_interrupt();
		tester.shift_ir(jcg_pkg::OP_CFG_INT, f);
		wait_clk(20);
		check("busy_stopped", 32'h0, {31'h0, config_busy});
		check("done_stopped", 32'h0, {31'h0, config_done});
		check("pins_off_intr", 32'h0, {28'h0, oes()});
	endtask

	task automatic t_extest();
		tester.shift_ir(jcg_pkg::OP_SAMPLE, f);
		tester.shift_dr(8, 32'hC9, d);
		tester.shift_ir(jcg_pkg::OP_EXTEST, f);
		wait_clk(20);
		check("extest_oe", 32'h5, {28'h0, oes()});
		check("extest_out", 32'h1, {30'h0, pin_drv[2].out, pin_drv[0].out});
	endtask

	task automatic t_reconfig();
		int n;
		tester.shift_ir(jcg_pkg::OP_RECFG, f);
		wait_clk(20);
		check("busy_reload", 32'h1, {31'h0, config_busy});
		n = 0;
		while (config_done !== 1'b1 && n < jcg_pkg::CFG_CYC + 100)
		begin
			wait_clk(1);
			n++;
		end
		check("done_reload", 32'h1, {31'h0, config_done});
		check("busy_reload_end", 32'h0, {31'h0, config_busy});
	endtask

	// Pin modes that a device accepts once interrupted or while not loading
	task automatic t_highz_clamp();
		tester.shift_ir(jcg_pkg::OP_HIGHZ, f);
		check("highz_oe", 32'h0, {28'h0, oes()});
		tester.shift_ir(jcg_pkg::OP_CLAMP, f);
		check("clamp_oe", 32'h5, {28'h0, oes()});
		check("clamp_out", 32'h1, {30'h0, pin_drv[2].out, pin_drv[0].out});
	endtask

	// User drive returns after reconfiguration; chip-wide enable only gates it
	task automatic t_user_mode();
		core_pin = 8'h3F;
		wait_clk(5);
		check("user_oe", 32'h7, {28'h0, oes()});
		chip_wide_output_enable = 1'b0;
		wait_clk(5);
		check("user_oe_gated", 32'h0, {28'h0, oes()});
		check("done_kept", 32'h1, {31'h0, config_done});
		chip_wide_output_enable = 1'b1;
	endtask

	// Restart by a low pulse on the request pin instead of the instruction
	task automatic t_request_restart();
		tester.shift_ir(jcg_pkg::OP_CFG_INT, f);
		wait_clk(20);
		check("done_intr2", 32'h0, {31'h0, config_done});
		check("pins_off_intr2", 32'h0, {28'h0, oes()});
		config_request_n = 1'b0;
		wait_clk(10);
		check("busy_request_low", 32'h0, {31'h0, config_busy});
		config_request_n = 1'b1;
		wait_clk(20);
		check("busy_request", 32'h1, {31'h0, config_busy});
	endtask

	initial
	begin
		#60000;
		fails++;
		close_out();
	end

	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		config_request_n = 1'b0;
		chip_wide_clear_n = 1'b1;
		chip_wide_output_enable = 1'b1;
		core_pin = '0;
		pin_in = 4'hA;
		fails = 0;
		samples_checked = 0;
		// Test clock must tick during reset as well
		fork
			tester.idle(3);
			wait_clk(12);
		join
		rst_b = 1'b1;
		wait_clk(2);
		t_ir_capture();
		t_idcode_during_load();
		t_restricted_refused();
		t_interrupt();
		t_extest();
		t_highz_clamp();
		t_reconfig();
		t_user_mode();
		t_request_restart();
		close_out();
	end
endmodule
